// *** shxc_cmd_engine.sv ***
// SMBus mailbox slave and extended-command interpreter of the hub
`timescale 1ns/1ps
`default_nettype none
module shxc_cmd_engine
  import shxc_pkg::*;
#(
  parameter int NPORTS  = 5,
  parameter int BLK_MAX = 8
)(
  input  wire logic              clock,
  input  wire logic              srst,
  input  wire logic              smbus_clk,
  input  wire logic              smbus_data_in,
  output logic                   smbus_data_out,
  output logic                   smbus_data_oe,
  input  wire logic              addr_strap,
  input  wire logic              hub_configured,
  input  wire logic [6:0]        hs_hub_device_addr,
  input  wire logic [NPORTS-1:0] charger_port_mask,
  input  wire logic [NPORTS-1:0] hs_attach_seen,
  input  wire logic [NPORTS-1:0] ss_attach_seen,
  input  wire logic [NPORTS-1:0] hs_link_l2_sleep,
  input  wire logic [NPORTS-1:0] ss_link_u3_sleep,
  input  wire logic [NPORTS-1:0] port_power_on,
  input  wire logic [NPORTS-1:0] dplus_above_threshold,
  input  wire logic [NPORTS-1:0] dminus_above_threshold,
  output logic [NPORTS-1:0]      port_power_forced_off,
  output logic [NPORTS-1:0]      ss_termination_off,
  output logic [NPORTS-1:0]      hs_termination_off,
  output logic                   ctl_req,
  output logic                   ctl_write,
  output logic [7:0]             ctl_addr,
  output logic [7:0]             ctl_wdata,
  input  wire logic              ctl_ack,
  input  wire logic [7:0]        ctl_rdata,
  output logic                   cmd_busy
);

  localparam int SLOTS = 2 + BLK_MAX;
  localparam int CW    = 8 * (SLOTS + 1);

  if (NPORTS < 1 || NPORTS > 8 || BLK_MAX < NPORTS - 1 || BLK_MAX > 64)
  begin : g_bad_param
    $error("shxc_cmd_engine: NPORTS or BLK_MAX out of range");
  end

  function automatic logic [7:0] bit_at(input logic b, input int pos);
    logic [7:0] r;
    r      = '0;
    r[pos] = b;
    return r;
  endfunction : bit_at

  function automatic logic is_ctl(input logic [7:0] c);
    return c == CMD_CTL_RD || c == CMD_CTL_WR || c == CMD_BLK_RD || c == CMD_BLK_WR;
  endfunction : is_ctl

  function automatic logic is_block(input logic [7:0] c);
    return c == CMD_BLK_RD || c == CMD_BLK_WR;
  endfunction : is_block

  ////////////////////////////////////////////////////////////////////////////
  // Link domain: frame tracking on the SMBus clock
  logic       start_tog;
  logic       start_seen;
  logic       active;
  logic       rd_mode;
  logic       ack_en;
  logic       opc_hi;
  logic       exec_arm;
  logic       exec_fire;
  logic [3:0] bit_cnt;
  logic [2:0] byte_idx;
  logic [7:0] sh;
  logic [7:0] tx;
  logic [6:0] ptr;
  logic [6:0] addr_s1;
  logic [6:0] addr_s2;
  logic [7:0] mbox [MBOX_BYTES];
  logic [CW-1:0] cmd_word;
  logic          res_valid;
  logic [CW-1:0] res_word;
  logic       new_start;
  logic       byte_done;
  logic       nack;
  logic       tx_load;
  logic [7:0] rx_byte;

  assign new_start = start_tog != start_seen;
  assign rx_byte   = {sh[6:0], smbus_data_in};
  assign byte_done = active && !new_start && bit_cnt == BIT_LAST;
  assign nack      = active && !new_start && bit_cnt == BIT_ACK && rd_mode
                     && byte_idx > IDX_RDCNT && smbus_data_in;
  assign tx_load   = active && !new_start && bit_cnt == BIT_ACK && rd_mode && !nack;

  // Start: data falls while the clock is high; the clock can be stopped here
  always_ff @(negedge smbus_data_in or posedge srst)
  begin
    if (srst)
      start_tog <= 1'b0;
    else if (smbus_clk)
      start_tog <= ~start_tog;
  end

  // Bit and byte counting, address match, direction
  always_ff @(posedge smbus_clk or posedge srst)
  begin
    if (srst)
    begin
      start_seen <= 1'b0;
      active     <= 1'b0;
      bit_cnt    <= '0;
      byte_idx   <= IDX_ADDR;
      sh         <= '0;
      rd_mode    <= 1'b0;
      ack_en     <= 1'b0;
    end
    else if (new_start)
    begin
      start_seen <= start_tog;
      active     <= 1'b1;
      bit_cnt    <= 4'h1;
      byte_idx   <= IDX_ADDR;
      sh         <= {7'h00, smbus_data_in};
      ack_en     <= 1'b0;
    end
    else if (active)
    begin
      if (bit_cnt == BIT_ACK)
      begin
        bit_cnt <= '0;
        if (nack)
          active <= 1'b0;   // Master ends a read after the count byte or any later byte
      end
      else
      begin
        sh      <= rx_byte;
        bit_cnt <= bit_cnt + 4'h1;
      end
      if (byte_done)
      begin
        if (byte_idx < IDX_PAY)
          byte_idx <= byte_idx + 3'h1;
        if (byte_idx == IDX_ADDR)
        begin
          rd_mode <= rx_byte[0];
          ack_en  <= rx_byte[7:1] == addr_s2;
          if (rx_byte[7:1] != addr_s2)
            active <= 1'b0;                            // Not ours: stay silent
        end
        else
          ack_en <= !rd_mode;
      end
    end
  end

  // Read data: count byte first, then mailbox bytes from the pointer
  always_ff @(posedge smbus_clk or posedge srst)
  begin
    if (srst)
      tx <= '0;
    else if (tx_load)
      tx <= (byte_idx == IDX_RDCNT) ? RD_COUNT : mbox[ptr];
    else if (active && bit_cnt != BIT_ACK)
      tx <= {tx[6:0], 1'b0};
  end

  // Pointer, opcode recognition and command capture
  always_ff @(posedge smbus_clk or posedge srst)
  begin
    if (srst)
    begin
      ptr       <= '0;
      opc_hi    <= 1'b0;
      exec_arm  <= 1'b0;
      exec_fire <= 1'b0;
      cmd_word  <= '0;
    end
    else
    begin
      exec_fire <= 1'b0;
      if (tx_load && byte_idx != IDX_RDCNT)
        ptr <= ptr + 7'h01;
      if (byte_done && !rd_mode)
      begin
        case (byte_idx)
          IDX_OFS_HI: opc_hi <= rx_byte == OPC_HI;
          IDX_OFS_LO:
          begin
            ptr      <= rx_byte[6:0];
            exec_arm <= opc_hi && rx_byte == OPC_LO;
          end
          IDX_TERM:
          begin
            if (exec_arm && rx_byte == OPC_END)
            begin
              exec_fire          <= 1'b1;
              cmd_word[CW-1 -: 8] <= mbox[OFF_CMD];
              for (int k = 0; k < SLOTS; k++)
                cmd_word[8*k +: 8] <= mbox[OFF_DATA1 + k];
            end
          end
          IDX_PAY: ptr <= ptr + 7'h01;
          default: ;
        endcase
      end
    end
  end

  // Mailbox storage; results land first, a master write on the same edge wins
  always_ff @(posedge smbus_clk or posedge srst)
  begin
    if (srst)
    begin
      for (int i = 0; i < MBOX_BYTES; i++)
        mbox[i] <= '0;
    end
    else
    begin
      if (res_valid)
      begin
        mbox[OFF_STATUS] <= res_word[CW-1 -: 8];
        for (int k = 0; k < SLOTS; k++)
          mbox[OFF_DATA1 + k] <= res_word[8*k +: 8];
      end
      if (byte_done && !rd_mode && byte_idx == IDX_PAY)
        mbox[ptr] <= rx_byte;
    end
  end

  // Drive data low on the falling clock: ack slot or a zero read bit
  always_ff @(negedge smbus_clk or posedge srst)
  begin
    if (srst)
    begin
      smbus_data_oe  <= 1'b0;
      smbus_data_out <= 1'b0;
    end
    else
    begin
      smbus_data_oe  <= active && ((bit_cnt == BIT_ACK) ? ack_en
                        : (rd_mode && byte_idx != IDX_ADDR && !tx[7]));
      smbus_data_out <= 1'b0;   // Open drain: only ever pulls low
    end
  end

  // Slave address is quasi-static; two flops bring it to the link clock
  logic [6:0] cur_addr;
  always_ff @(posedge smbus_clk or posedge srst)
  begin
    if (srst)
    begin
      addr_s1 <= ADDR_FIXED_DEFAULT;
      addr_s2 <= ADDR_FIXED_DEFAULT;
    end
    else
    begin
      addr_s1 <= cur_addr;
      addr_s2 <= addr_s1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Crossings between the link and the system clock
  logic          cmd_valid;
  logic [CW-1:0] cmd_data;
  logic [CW-1:0] res_pack;
  shxc_state_t   state;

  shxc_word_cdc #(.W(CW)) u_cmd_cdc (
    .rst       (srst),
    .src_clk   (smbus_clk),
    .src_valid (exec_fire),
    .src_data  (cmd_word),
    .dst_clk   (clock),
    .dst_valid (cmd_valid),
    .dst_data  (cmd_data)
  );

  shxc_word_cdc #(.W(CW)) u_res_cdc (
    .rst       (srst),
    .src_clk   (clock),
    .src_valid (state == ST_REPLY),
    .src_data  (res_pack),
    .dst_clk   (smbus_clk),
    .dst_valid (res_valid),
    .dst_data  (res_word)
  );

  ////////////////////////////////////////////////////////////////////////////
  // System domain: command interpreter
  logic       strap_s1;
  logic       strap_s2;
  logic [1:0] strap_age;
  logic [6:0] default_addr;
  logic [7:0] code;
  logic [7:0] status;
  logic [7:0] slot [SLOTS];
  logic [7:0] res [SLOTS];
  logic [7:0] idx;
  logic [7:0] cnt;
  logic [7:0] conn_b [NPORTS];
  logic [7:0] pwr_b [NPORTS];
  logic [7:0] line_b [NPORTS];

  // Per-port status bytes; reserved bits stay zero
  for (genvar i = 0; i < NPORTS; i++)
  begin : g_port
    assign conn_b[i] = bit_at(hs_link_l2_sleep[i], CS_L2) | bit_at(ss_link_u3_sleep[i], CS_U3)
                     | bit_at(hs_attach_seen[i], CS_HS) | bit_at(ss_attach_seen[i], CS_SS);
    assign pwr_b[i]  = {7'h00, port_power_on[i]};
    assign line_b[i] = bit_at(dminus_above_threshold[i], LS_DM)
                     | bit_at(dplus_above_threshold[i], LS_DP);
  end

  always_comb
  begin
    res_pack[CW-1 -: 8] = status;
    for (int k = 0; k < SLOTS; k++)
      res_pack[8*k +: 8] = res[k];
  end

  // Strap is caught a few cycles after reset release, once synchronised
  always_ff @(posedge clock)
  begin
    if (srst)
    begin
      strap_s1     <= 1'b0;
      strap_s2     <= 1'b0;
      strap_age    <= '0;
      default_addr <= ADDR_FIXED_DEFAULT;
      cur_addr     <= ADDR_FIXED_DEFAULT;
    end
    else
    begin
      strap_s1 <= addr_strap;
      strap_s2 <= strap_s1;
      if (strap_age != 2'h3)
        strap_age <= strap_age + 2'h1;
      if (strap_age == 2'h2)
      begin
        default_addr <= {ADDR_STRAP_BASE, strap_s2};
        cur_addr     <= {ADDR_STRAP_BASE, strap_s2};
      end
      else if (state == ST_RUN && code == CMD_SET_ADDR)
        cur_addr <= slot[0][SA_DEFAULT] ? default_addr : slot[0][6:0];
    end
  end

  // Sequencer; a command arriving while busy is dropped
  always_ff @(posedge clock)
  begin
    if (srst)
    begin
      state    <= ST_IDLE;
      idx      <= '0;
      cnt      <= '0;
      cmd_busy <= 1'b0;
    end
    else
    begin
      case (state)
        ST_IDLE:
        begin
          if (cmd_valid)
          begin
            state    <= ST_RUN;
            cmd_busy <= 1'b1;
          end
        end
        ST_RUN:
        begin
          idx <= '0;
          cnt <= !is_block(code) ? 8'h01
                 : (slot[1] > 8'(BLK_MAX)) ? 8'(BLK_MAX) : slot[1];
          if (is_ctl(code) && !(is_block(code) && slot[1] == 8'h00))
            state <= ST_CTL;
          else
            state <= ST_REPLY;
        end
        ST_CTL: state <= ST_WAIT;
        ST_WAIT:
        begin
          if (ctl_ack)
          begin
            idx   <= idx + 8'h01;
            state <= (idx + 8'h01 >= cnt) ? ST_REPLY : ST_CTL;
          end
        end
        ST_REPLY:
        begin
          state    <= ST_IDLE;
          cmd_busy <= 1'b0;
        end
        default: state <= ST_IDLE;
      endcase
    end
  end

  // Command latch and result bytes
  always_ff @(posedge clock)
  begin
    if (srst)
    begin
      code   <= '0;
      status <= '0;
      for (int k = 0; k < SLOTS; k++)
      begin
        slot[k] <= '0;
        res[k]  <= '0;
      end
    end
    else if (state == ST_IDLE && cmd_valid)
    begin
      code   <= cmd_data[CW-1 -: 8];
      status <= STAT_OK;
      for (int k = 0; k < SLOTS; k++)
      begin
        slot[k] <= cmd_data[8*k +: 8];
        res[k]  <= cmd_data[8*k +: 8];   // Untouched slots read back as written
      end
    end
    else if (state == ST_RUN)
    begin
      case (code)
        CMD_GET_DEF:  res[0] <= {1'b0, ADDR_FIXED_DEFAULT};
        CMD_HUB_INFO: res[0] <= {hub_configured, hs_hub_device_addr};
        CMD_CHG_MASK: res[0] <= 8'(charger_port_mask);
        CMD_CONN, CMD_PWR, CMD_LINE:
        begin
          for (int i = 0; i < NPORTS; i++)
            res[1 + i] <= !slot[0][i] ? 8'h00
                          : (code == CMD_CONN) ? conn_b[i]
                          : (code == CMD_PWR) ? pwr_b[i] : line_b[i];
        end
        CMD_SET_ADDR, CMD_DISABLE, CMD_CTL_RD, CMD_CTL_WR, CMD_BLK_RD, CMD_BLK_WR: ;
        default: status <= STAT_BAD;
      endcase
    end
    else if (state == ST_WAIT && ctl_ack && !ctl_write)
    begin
      if (code == CMD_CTL_RD)
        res[1] <= ctl_rdata;
      else
        res[2 + idx] <= ctl_rdata;
    end
  end

  // Charger controller access, one byte per request
  always_ff @(posedge clock)
  begin
    if (srst)
    begin
      ctl_req   <= 1'b0;
      ctl_write <= 1'b0;
      ctl_addr  <= '0;
      ctl_wdata <= '0;
    end
    else if (state == ST_CTL)
    begin
      ctl_req   <= 1'b1;
      ctl_write <= code == CMD_CTL_WR || code == CMD_BLK_WR;
      ctl_addr  <= slot[0] + idx;
      ctl_wdata <= (code == CMD_CTL_WR) ? slot[1] : slot[2 + idx];
    end
    else if (ctl_ack)
      ctl_req <= 1'b0;
  end

  // Forced-off controls; bits 6:3 of each request are ignored
  always_ff @(posedge clock)
  begin
    if (srst)
    begin
      port_power_forced_off <= '0;
      ss_termination_off    <= '0;
      hs_termination_off    <= '0;
    end
    else if (state == ST_RUN && code == CMD_DISABLE)
    begin
      for (int i = 0; i < NPORTS; i++)
      begin
        if (slot[0][i] && slot[1 + i][PD_APPLY])
        begin
          port_power_forced_off[i] <= slot[1 + i][PD_PWR];
          ss_termination_off[i]    <= slot[1 + i][PD_SS];
          hs_termination_off[i]    <= slot[1 + i][PD_HS];
        end
      end
    end
  end

endmodule : shxc_cmd_engine
`default_nettype wire

// *** shxc_cmd_engine_asserts.sv ***
// Port-level checks of the hub extended-command engine
`timescale 1ns/1ps
`default_nettype none
module shxc_cmd_engine_asserts #(
  parameter int NPORTS = 5
)(
  input wire logic              clock,
  input wire logic              srst,
  input wire logic              smbus_data_out,
  input wire logic              cmd_busy,
  input wire logic              ctl_req,
  input wire logic              ctl_write,
  input wire logic [7:0]        ctl_addr,
  input wire logic [7:0]        ctl_wdata,
  input wire logic              ctl_ack,
  input wire logic [NPORTS-1:0] port_power_forced_off,
  input wire logic [NPORTS-1:0] ss_termination_off,
  input wire logic [NPORTS-1:0] hs_termination_off
);
  // All checks sample on the system clock
  default clocking cb @(posedge clock);
  endclocking
  default disable iff (srst);

  a_ctl_hold: assert property (ctl_req && !ctl_ack |=> ctl_req && $stable({ctl_write, ctl_addr, ctl_wdata}))
    else $error("controller request changed before acknowledge");
  a_ctl_drop: assert property (ctl_ack |-> ##[1:2] !ctl_req)
    else $error("controller request held after acknowledge");
  a_req_busy: assert property (ctl_req |-> cmd_busy)
    else $error("controller access outside a command");
  a_req_start: assert property ($rose(ctl_req) |-> $past(cmd_busy))
    else $error("controller request without a running command");
  a_busy_end: assert property ($rose(cmd_busy) |-> ##[1:400] !cmd_busy)
    else $error("command never completed");
  a_reset_clear: assert property ($fell(srst) |-> !cmd_busy && !ctl_req && !port_power_forced_off)
    else $error("outputs not cleared by reset");
  // Disable outputs may only move while a command runs
  a_dis_cause: assert property ($changed({port_power_forced_off, ss_termination_off, hs_termination_off})
    |-> $past(cmd_busy))
    else $error("disable outputs changed with no command");
  a_line_drive: assert property (!smbus_data_out)
    else $error("data line driven high");

  c_ctl_write: cover property (ctl_ack && ctl_write);
  c_ctl_read: cover property (ctl_ack && !ctl_write);
  c_cmd_run: cover property ($rose(cmd_busy));
endmodule : shxc_cmd_engine_asserts

bind shxc_cmd_engine shxc_cmd_engine_asserts #(.NPORTS(NPORTS)) i_shxc_cmd_engine_asserts (.clock, .srst,
  .smbus_data_out, .cmd_busy, .ctl_req, .ctl_write, .ctl_addr, .ctl_wdata, .ctl_ack,
  .port_power_forced_off, .ss_termination_off, .hs_termination_off);
`default_nettype wire

// *** shxc_pkg.sv ***
// Constants, types and command codes for the SMBus hub extended-command engine
package shxc_pkg;

  // Mailbox layout
  localparam int         MBOX_BYTES = 128;
  localparam int         OFF_CMD    = 0;
  localparam int         OFF_STATUS = 1;
  localparam int         OFF_DATA1  = 2;
  localparam logic [7:0] RD_COUNT   = 8'h80;

  // Special opcode framing
  localparam logic [7:0] OPC_HI  = 8'h99;
  localparam logic [7:0] OPC_LO  = 8'h3e;
  localparam logic [7:0] OPC_END = 8'h00;

  // Byte positions within one SMBus frame
  localparam logic [2:0] IDX_ADDR   = 3'h0;
  localparam logic [2:0] IDX_OFS_HI = 3'h1;
  localparam logic [2:0] IDX_RDCNT  = 3'h1;
  localparam logic [2:0] IDX_OFS_LO = 3'h2;
  localparam logic [2:0] IDX_TERM   = 3'h3;
  localparam logic [2:0] IDX_PAY    = 3'h4;
  localparam logic [3:0] BIT_LAST   = 4'h7;
  localparam logic [3:0] BIT_ACK    = 4'h8;

  // Slave addresses
  localparam logic [6:0] ADDR_FIXED_DEFAULT = 7'h2d;
  localparam logic [5:0] ADDR_STRAP_BASE    = 6'h16;

  // Extended command codes
  localparam logic [7:0] CMD_SET_ADDR = 8'h00;
  localparam logic [7:0] CMD_GET_DEF  = 8'h01;
  localparam logic [7:0] CMD_HUB_INFO = 8'h02;
  localparam logic [7:0] CMD_CHG_MASK = 8'h03;
  localparam logic [7:0] CMD_CONN     = 8'h80;
  localparam logic [7:0] CMD_PWR      = 8'h81;
  localparam logic [7:0] CMD_DISABLE  = 8'h82;
  localparam logic [7:0] CMD_LINE     = 8'h83;
  localparam logic [7:0] CMD_CTL_RD   = 8'h84;
  localparam logic [7:0] CMD_CTL_WR   = 8'h85;
  localparam logic [7:0] CMD_BLK_RD   = 8'h86;
  localparam logic [7:0] CMD_BLK_WR   = 8'h87;

  // Outcome codes written to the status byte
  localparam logic [7:0] STAT_OK  = 8'h01;
  localparam logic [7:0] STAT_BAD = 8'h80;

  // Field positions
  localparam int SA_DEFAULT = 7;
  localparam int CS_L2      = 5;
  localparam int CS_U3      = 4;
  localparam int CS_HS      = 1;
  localparam int CS_SS      = 0;
  localparam int PD_APPLY   = 7;
  localparam int PD_PWR     = 2;
  localparam int PD_SS      = 1;
  localparam int PD_HS      = 0;
  localparam int LS_DM      = 1;
  localparam int LS_DP      = 0;

  typedef enum logic [2:0] {ST_IDLE, ST_RUN, ST_CTL, ST_WAIT, ST_REPLY} shxc_state_t;

endpackage : shxc_pkg

// *** shxc_smbus_master.sv ***
// SMBus master model that owns the link clock and data
`timescale 1ns/1ps
`default_nettype none
module shxc_smbus_master (
  output logic       smbus_clk,
  output logic       sda_drv,
  input  wire logic  sda,
  output logic       rx_stb,
  output logic [7:0] rx_byte
);
  // Clock parks high and data goes to the pull-up between frames
  initial
  begin
    smbus_clk = 1'b1;
    sda_drv   = 1'b1;
    rx_stb    = 1'b0;
    rx_byte   = 8'h00;
  end

  ////////////////////////////////////////////////////////////
  // Start, also used as repeated start before a read
  task automatic start();
    sda_drv = 1'b1;
    #6 smbus_clk = 1'b1;
    #6 sda_drv = 1'b0;
    #6 smbus_clk = 1'b0;
  endtask : start

  // Stop may end any frame, reads included
  task automatic stop();
    sda_drv = 1'b0;
    #6 smbus_clk = 1'b1;
    #6 sda_drv = 1'b1;
  endtask : stop

  // Byte MSB first then ninth bit; a released bit reads the wire
  task automatic xfer(input logic [7:0] b, input logic mack, input logic rd);
    logic [7:0] r;
    for (int i = 7; i >= 0; i--)
    begin
      sda_drv = b[i];
      #6 smbus_clk = 1'b1;
      r[i] = sda;
      #6 smbus_clk = 1'b0;
    end
    sda_drv = mack;
    #6 smbus_clk = 1'b1;
    rx_byte = rd ? r : {7'h00, !sda};
    #6 smbus_clk = 1'b0;
    rx_stb = !rx_stb;
  endtask : xfer
endmodule : shxc_smbus_master
`default_nettype wire

// *** shxc_word_cdc.sv ***
// Toggle-pulse word crossing between two clock domains
`timescale 1ns/1ps
`default_nettype none
module shxc_word_cdc #(
  parameter int W = 8
)(
  input  wire logic         rst,
  input  wire logic         src_clk,
  input  wire logic         src_valid,
  input  wire logic [W-1:0] src_data,
  input  wire logic         dst_clk,
  output logic              dst_valid,
  output logic [W-1:0]      dst_data
);

  logic         src_tog;
  logic [W-1:0] hold;
  logic         sync1;
  logic         sync2;
  logic         sync3;

  if (W < 1)
  begin : g_bad_width
    $error("shxc_word_cdc: W must be positive");
  end

  // Source holds the word until the next event; one word in flight only
  always_ff @(posedge src_clk or posedge rst)
  begin
    if (rst)
    begin
      src_tog <= 1'b0;
      hold    <= '0;
    end
    else if (src_valid)
    begin
      src_tog <= ~src_tog;
      hold    <= src_data;
    end
  end

  // Destination: sync1 feeds only sync2; edge seen between sync2 and sync3
  always_ff @(posedge dst_clk or posedge rst)
  begin
    if (rst)
    begin
      sync1     <= 1'b0;
      sync2     <= 1'b0;
      sync3     <= 1'b0;
      dst_valid <= 1'b0;
      dst_data  <= '0;
    end
    else
    begin
      sync1     <= src_tog;
      sync2     <= sync1;
      sync3     <= sync2;
      dst_valid <= sync2 ^ sync3;
      if (sync2 ^ sync3)
        dst_data <= hold;   // Held stable for two edges already
    end
  end

endmodule : shxc_word_cdc
`default_nettype wire

// *** tb_shxc_cmd_engine.sv ***
// Self-checking bench for the hub extended-command engine
`timescale 1ns/1ps
`default_nettype none
module tb_shxc_cmd_engine
  import shxc_pkg::*;
;
  logic       clock = 1'b0;
  logic       srst  = 1'b0;
  logic       strap = 1'b1;
  logic       hub_configured, ctl_req, ctl_write, ctl_ack, ack_d, cmd_busy, smbus_clk, sda_drv, rx_stb;
  logic       smbus_data_out, smbus_data_oe;
  logic [6:0] hs_hub_device_addr;
  logic [4:0] charger_port_mask, hs_attach_seen, ss_attach_seen, hs_link_l2_sleep, ss_link_u3_sleep;
  logic [4:0] port_power_on, dplus_above_threshold, dminus_above_threshold, fo, so, ho;
  logic [4:0] port_power_forced_off, ss_termination_off, hs_termination_off;
  logic [7:0] ctl_addr, ctl_wdata, ctl_rdata, rx_byte, creg [256], cexp [256], d [1:8], exp_q [$];
  logic [7:0] cmds [13] = '{8'h01, 8'h02, 8'h03, 8'h80, 8'h81, 8'h82, 8'h83, 8'h84, 8'h85, 8'h86, 8'h87,
                            8'h82, 8'h55};
  wire        sda = sda_drv & ~smbus_data_oe;
  int         bad_count, num_checks, cyc, seed = 66;

  ////////////////////////////////////////////////////////////
  // Engine and link master; strap starts on the high address
  shxc_cmd_engine i_shxc_cmd_engine (.clock, .srst, .smbus_clk, .smbus_data_in(sda), .smbus_data_out,
    .smbus_data_oe, .addr_strap(strap), .hub_configured, .hs_hub_device_addr, .charger_port_mask,
    .hs_attach_seen, .ss_attach_seen, .hs_link_l2_sleep, .ss_link_u3_sleep, .port_power_on,
    .dplus_above_threshold, .dminus_above_threshold, .port_power_forced_off, .ss_termination_off,
    .hs_termination_off, .ctl_req, .ctl_write, .ctl_addr, .ctl_wdata, .ctl_ack, .ctl_rdata, .cmd_busy);
  shxc_smbus_master i_shxc_smbus_master (.smbus_clk, .sda_drv, .sda, .rx_stb, .rx_byte);

  // System clock
  always #5 clock = ~clock;

  // Controller stand-in stalls at random; read data churns outside acknowledges
  always @(negedge clock)
  begin
    ack_d     <= ctl_ack;
    ctl_ack   <= 1'b0;
    ctl_rdata <= ~ctl_rdata;
    if (ctl_req && !ctl_ack && !ack_d && $random(seed) % 3 == 0)
    begin
      ctl_ack   <= 1'b1;
      ctl_rdata <= creg[ctl_addr];
      if (ctl_write)
        creg[ctl_addr] <= ctl_wdata;
    end
  end

  // Hang guard
  always @(posedge clock)
  begin
    cyc++;
    if (cyc == 30000)
    begin
      bad_count++;
      report_and_stop();
    end
  end

  // Oldest note is matched against each byte or acknowledge seen on the link
  always @(rx_stb)
    if ($time > 0)   // Power-up settle of the strobe is no byte
      check(rx_byte, exp_q.pop_front());

  ////////////////////////////////////////////////////////////
  task automatic check(input logic [7:0] got, input logic [7:0] exp);
    num_checks++;
    if (got !== exp)
    begin
      bad_count++;
      $display("[ERR] %0t got %h exp %h", $time, got, exp);
    end
  endtask : check

  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", num_checks, bad_count);
    if (bad_count == 0 && num_checks > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask : report_and_stop

  task automatic wb(input logic [7:0] b, input logic [7:0] e);
    exp_q.push_back(e);
    i_shxc_smbus_master.xfer(b, 1'b1, 1'b0);
  endtask : wb

  task automatic rb(input logic [7:0] e, input logic last);
    exp_q.push_back(e);
    i_shxc_smbus_master.xfer(8'hff, last, 1'b1);
  endtask : rb

  // Hub status inputs only move between commands
  task automatic rnd();
    logic [63:0] rv;
    rv = {$random(seed), $random(seed)};
    {hub_configured, hs_hub_device_addr, charger_port_mask, hs_attach_seen, ss_attach_seen, hs_link_l2_sleep,
      ss_link_u3_sleep, port_power_on, dplus_above_threshold, dminus_above_threshold} = rv[47:0];
  endtask : rnd

  // Load mailbox, execute, read back status and data slots
  task automatic run(input logic [7:0] cmd, input logic [6:0] aw, input logic [6:0] ar);
    logic [7:0] e [1:8];
    logic [7:0] st;
    e = d;
    @(negedge clock);
    rnd();
    i_shxc_smbus_master.start();
    wb({aw, 1'b0}, 8'h01);
    wb(8'h00, 8'h01);
    wb(8'h00, 8'h01);
    wb(8'h0a, 8'h01);
    wb(cmd, 8'h01);
    wb(8'h00, 8'h01);
    foreach (d[k]) wb(d[k], 8'h01);
    i_shxc_smbus_master.start();
    wb({aw, 1'b0}, 8'h01);
    wb(8'h99, 8'h01);
    wb(8'h3e, 8'h01);
    wb(8'h00, 8'h01);
    i_shxc_smbus_master.stop();
    if (cmd == 8'h01) e[1] = 8'h2d;
    if (cmd == 8'h02) e[1] = {hub_configured, hs_hub_device_addr};
    if (cmd == 8'h03) e[1] = {3'h0, charger_port_mask};
    if (cmd == 8'h84) e[2] = cexp[d[1]];
    if (cmd == 8'h85) cexp[d[1]] = d[2];
    for (int i = 0; i < 5; i++)
    begin
      st = {2'h0, hs_link_l2_sleep[i], ss_link_u3_sleep[i], 2'h0, hs_attach_seen[i], ss_attach_seen[i]};
      if (cmd == 8'h81) st = {7'h00, port_power_on[i]};
      if (cmd == 8'h83) st = {6'h00, dminus_above_threshold[i], dplus_above_threshold[i]};
      if (cmd == 8'h80 || cmd == 8'h81 || cmd == 8'h83) e[2+i] = d[1][i] ? st : 8'h00;
      if (cmd == 8'h82 && d[1][i] && d[2+i][7]) {fo[i], so[i], ho[i]} = d[2+i][2:0];
      if (cmd == 8'h86 && i < d[2]) e[3+i] = cexp[d[1] + 8'(i)];
      if (cmd == 8'h87 && i < d[2]) cexp[d[1] + 8'(i)] = d[3+i];
    end
    for (int n = 0; n < 40 && cmd_busy !== 1'b1; n++) @(negedge clock);
    for (int n = 0; n < 400 && cmd_busy !== 1'b0; n++) @(negedge clock);
    check({7'h00, cmd_busy}, 8'h00);
    #100;
    i_shxc_smbus_master.start();
    wb({ar, 1'b0}, 8'h01);
    wb(8'h00, 8'h01);
    wb(8'h01, 8'h01);
    i_shxc_smbus_master.start();
    wb({ar, 1'b1}, 8'h01);
    rb(8'h80, 1'b0);
    rb(cmd == 8'h55 ? 8'h80 : 8'h01, 1'b0);
    foreach (e[k]) rb(e[k], k == 8);
    i_shxc_smbus_master.stop();
    check({3'h0, port_power_forced_off}, {3'h0, fo});
    check({3'h0, ss_termination_off}, {3'h0, so});
    check({3'h0, hs_termination_off}, {3'h0, ho});
  endtask : run

  ////////////////////////////////////////////////////////////
  // Main sequence: every command twice, then address moves
  initial
  begin
    {ctl_ack, ack_d, ctl_rdata, fo, so, ho} = '0;
    foreach (cexp[i]) cexp[i] = 8'(i) ^ 8'ha5;
    creg = cexp;
    rnd();
    #1 srst = 1'b1;   // A true edge, so link-side flops reset too
    repeat (16) @(negedge clock);
    srst = 1'b0;
    repeat (12) @(negedge clock);
    repeat (2)
      foreach (cmds[j])
      begin
        foreach (d[k]) d[k] = 8'($random(seed));
        if (cmds[j][7:1] == 7'h43) d[2] = d[2] % 8'd6;
        run(cmds[j], 7'h2d, 7'h2d);
      end
    d[1] = 8'h33;
    run(8'h00, 7'h2d, 7'h33);
    i_shxc_smbus_master.start();
    wb({7'h2d, 1'b0}, 8'h00);
    i_shxc_smbus_master.stop();
    d[1] = 8'hb3;
    run(8'h00, 7'h33, 7'h2d);
    // Second reset on the low strap; the fixed default must not follow it
    @(negedge clock);
    strap = 1'b0;
    {fo, so, ho} = '0;
    srst = 1'b1;
    repeat (16) @(negedge clock);
    srst = 1'b0;
    repeat (12) @(negedge clock);
    run(8'h01, 7'h2c, 7'h2c);
    foreach (creg[i]) check(creg[i], cexp[i]);
    report_and_stop();
  end
endmodule : tb_shxc_cmd_engine
`default_nettype wire
